// >>> vdc_pkg.sv
/*
  constants, register map and command codes of the video dram controller.
  assumes a 200 mhz system clock and a dual-port video dram on the pins.
*/
`default_nettype none

package vdc_pkg;
  // ****************************************
  // widths and clock
  // ****************************************
  localparam int CLK_NS  = 5;
  localparam int CNT_W   = 16;
  localparam int BUS_AW  = 4;
  localparam int BUS_DW  = 16;
  localparam int DQ_W    = 8;
  localparam int ADR_W   = 8;
  localparam int CMD_W   = 3;
  localparam int ROW_LSB = 8;
  localparam int COL_LSB = 0;

  // ****************************************
  // timing, in ns and in cycles
  // ****************************************
  localparam int RCD_NS     = 30;
  localparam int CAS_NS     = 70;
  localparam int PRE_NS     = 70;
  localparam int SH_HALF_NS = 20;
  localparam int PWR_NS     = 200000;
  localparam int REF_WIN_NS = 4000000;
  localparam int REF_ROWS   = 256;
  localparam int PWR_CYC    = PWR_NS / CLK_NS;
  localparam logic [CNT_W-1:0] RCD_CYC =
    CNT_W'((RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CAS_CYC =
    CNT_W'((CAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PRE_CYC =
    CNT_W'((PRE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SH_CYC =
    CNT_W'((SH_HALF_NS + CLK_NS - 1) / CLK_NS);
  // a longest interval, so rounded down
  localparam logic [CNT_W-1:0] REF_CYC =
    CNT_W'(REF_WIN_NS / (REF_ROWS * CLK_NS));
  localparam logic [3:0] INIT_CYCLES = 4'h8;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [BUS_AW-1:0] REG_CTRL  = 4'h0;
  localparam logic [BUS_AW-1:0] REG_ADDR  = 4'h1;
  localparam logic [BUS_AW-1:0] REG_WDATA = 4'h2;
  localparam logic [BUS_AW-1:0] REG_MASK  = 4'h3;
  localparam logic [BUS_AW-1:0] REG_SER   = 4'h4;
  localparam logic [BUS_AW-1:0] REG_STAT  = 4'h5;
  localparam logic [BUS_AW-1:0] REG_RDATA = 4'h6;
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_AUTOREF = 4;
  localparam int CTRL_GO      = 7;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_INIT    = 1;
  localparam int STAT_SBUSY   = 2;
  localparam int STAT_SOUT    = 3;
  localparam int STAT_REFP    = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [CMD_W-1:0] {
    CMD_READ, CMD_WRITE, CMD_MASK_WR, CMD_RD_XFER,
    CMD_PSEUDO_WR, CMD_COL_FIRST_REF, CMD_ROW_ONLY_REF
  } vdc_cmd_t;
  typedef enum logic [2:0] {
    ST_PWR, ST_IDLE, ST_SETUP, ST_ROW, ST_COL, ST_PRE
  } vdc_st_t;
  typedef enum logic [1:0] {SS_IDLE, SS_SET, SS_HI, SS_LO} vdc_sst_t;
endpackage

`default_nettype wire

// >>> vdc_sync_if.sv
/*
  carries one asynchronous bus into a synchroniser and its safe copy out.
  assumes the raw side is a pin and the safe side is the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface vdc_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] safe;
  modport mst (output raw, input safe);
  modport slv (input raw, output safe);
endinterface

`default_nettype wire

// >>> vdc_sync.sv
/*
  two-flop synchroniser for a bus of pin inputs.
  assumes the bits are sampled independently; no word coherency.
*/
`timescale 1ns/1ps
`default_nettype none

module vdc_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  vdc_sync_if.slv  sy
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } vdc_sync_t;

  vdc_sync_t q;
  vdc_sync_t d;

  // the first stage feeds the second and nothing else
  always_comb begin
    d      = q;
    d.meta = sy.raw;
    d.safe = q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sy.safe = q.safe;
endmodule

`default_nettype wire

// >>> vdc_ctrl.sv
/*
  host-side controller of a dual-port video dram: random port cycles,
  transfers, refresh, power-up sequence and single serial clock pulses.
  assumes a plain register port on the system clock and the dram pins
  outside; pin inputs are synchronised before use.
*/
// The register offsets and the strobed register port were decided locally.
// What this block does
// - device refreshes three ways; host gives 256 refreshes per 4 ms.
// - row address at row strobe fall, column at column strobe fall.
// - masked write: mask-enable low, new mask on data pins at row fall.
// - read transfer: row at row fall, tap at column fall.
// - write data valid at the later of column fall or write enable.
// - after power-up wait, then 8 refresh and 8 serial clocks.
// - 16-bit address goes as row byte then column byte.
`timescale 1ns/1ps
`default_nettype none

module vdc_ctrl #(
  parameter int PWR_WAIT_CYC = vdc_pkg::PWR_CYC
) (
  // clock and reset
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RST_N_I,
  // register port
  input  wire logic [vdc_pkg::BUS_AW-1:0] BUS_ADDR_I,
  input  wire logic [vdc_pkg::BUS_DW-1:0] BUS_WDATA_I,
  input  wire logic                       BUS_WR_I,
  input  wire logic                       BUS_RD_I,
  output logic      [vdc_pkg::BUS_DW-1:0] BUS_RDATA_O,
  // random port pins
  output logic                            ROW_STROBE_N_O,
  output logic                            COL_STROBE_N_O,
  output logic      [vdc_pkg::ADR_W-1:0]  ADDR_O,
  output logic                            WRITE_MASK_ENABLE_N_O,
  output logic                            TRANSFER_OUTPUT_ENABLE_N_O,
  input  wire logic [vdc_pkg::DQ_W-1:0]   MASK_DATA_IO_I,
  output logic      [vdc_pkg::DQ_W-1:0]   MASK_DATA_IO_O,
  output logic                            MASK_DATA_IO_OE_O,
  // serial port pins
  output logic                            SERIAL_ENABLE_N_O,
  output logic                            SERIAL_SHIFT_CLOCK_O,
  input  wire logic [vdc_pkg::DQ_W-1:0]   SERIAL_DATA_IO_I,
  output logic      [vdc_pkg::DQ_W-1:0]   SERIAL_DATA_IO_O,
  output logic                            SERIAL_DATA_IO_OE_O
);
  import vdc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    vdc_st_t            st;
    vdc_cmd_t           cmd;
    vdc_cmd_t           cmd_req;
    logic               cmd_pend;
    logic [CNT_W-1:0]   tmr;
    logic [CNT_W-1:0]   ref_tmr;
    logic [CNT_W-1:0]   stmr;
    logic [3:0]         init_cnt;
    logic [3:0]         s_left;
    logic [3:0]         hlp_rfall;
    logic               ref_pend;
    logic               autoref;
    logic               init_done;
    logic               ser_out;
    logic [BUS_DW-1:0]  addr;
    logic [DQ_W-1:0]    wdata;
    logic [DQ_W-1:0]    mask;
    logic [DQ_W-1:0]    rdata;
    logic [DQ_W-1:0]    sdata;
    logic [ADR_W-1:0]   addr_o;
    logic [DQ_W-1:0]    dq_o;
    logic [DQ_W-1:0]    sdq_o;
    logic               ras_n;
    logic               cas_n;
    logic               wmen_n;
    logic               xfer_n;
    logic               dq_oe;
    logic               ser_en_n;
    logic               shift_clk;
    logic               sdq_oe;
    vdc_sst_t           sst;
    logic [BUS_DW-1:0]  rd;
  } vdc_state_t;

  vdc_state_t q;
  vdc_state_t d;

  vdc_sync_if #(.W(DQ_W)) dq_if ();
  vdc_sync_if #(.W(DQ_W)) sdq_if ();

  assign dq_if.raw  = MASK_DATA_IO_I;
  assign sdq_if.raw = SERIAL_DATA_IO_I;

  vdc_sync #(.W(DQ_W)) u_dq_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .sy      (dq_if.slv)
  );

  vdc_sync #(.W(DQ_W)) u_sdq_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .sy      (sdq_if.slv)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic     go;
    logic     wr;
    logic     colc;
    vdc_cmd_t go_cmd;
    go     = 1'b0;
    go_cmd = CMD_COL_FIRST_REF;
    wr     = (q.cmd == CMD_WRITE) || (q.cmd == CMD_MASK_WR);
    colc   = (q.cmd != CMD_COL_FIRST_REF) && (q.cmd != CMD_ROW_ONLY_REF);
    d      = q;
    d.rd   = '0;

    // register writes; a command while one waits is dropped
    if (BUS_WR_I) begin
      case (BUS_ADDR_I)
        REG_CTRL: begin
          d.autoref = BUS_WDATA_I[CTRL_AUTOREF];
          if (BUS_WDATA_I[CTRL_GO] && !q.cmd_pend &&
              BUS_WDATA_I[CTRL_CMD_LSB +: CMD_W] <= CMD_ROW_ONLY_REF) begin
            d.cmd_pend = 1'b1;
            d.cmd_req  = vdc_cmd_t'(BUS_WDATA_I[CTRL_CMD_LSB +: CMD_W]);
          end
        end
        REG_ADDR:  d.addr  = BUS_WDATA_I;
        REG_WDATA: d.wdata = BUS_WDATA_I[DQ_W-1:0];
        REG_MASK:  d.mask  = BUS_WDATA_I[DQ_W-1:0];
        REG_SER: begin
          if (q.init_done && q.sst == SS_IDLE && q.s_left == '0) begin
            d.s_left = 4'h1;
            d.sdata  = BUS_WDATA_I[DQ_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // register reads, data in the next cycle only
    if (BUS_RD_I) begin
      case (BUS_ADDR_I)
        REG_CTRL:  d.rd[CTRL_AUTOREF] = q.autoref;
        REG_ADDR:  d.rd = q.addr;
        REG_WDATA: d.rd[DQ_W-1:0] = q.wdata;
        REG_MASK:  d.rd[DQ_W-1:0] = q.mask;
        REG_SER:   d.rd[DQ_W-1:0] = q.sdata;
        REG_RDATA: d.rd[DQ_W-1:0] = q.rdata;
        REG_STAT: begin
          d.rd[STAT_BUSY]  = (q.st != ST_IDLE) || q.cmd_pend;
          d.rd[STAT_INIT]  = q.init_done;
          d.rd[STAT_SBUSY] = (q.sst != SS_IDLE) || (q.s_left != '0);
          d.rd[STAT_SOUT]  = q.ser_out;
          d.rd[STAT_REFP]  = q.ref_pend;
        end
        default: ;
      endcase
    end

    // ****************************************
    // random port sequencer
    // ****************************************
    case (q.st)
      ST_PWR: begin
        if (q.tmr == CNT_W'(PWR_WAIT_CYC - 1)) begin
          d.st       = ST_IDLE;
          d.init_cnt = INIT_CYCLES;
          d.s_left   = INIT_CYCLES;
        end else begin
          d.tmr = q.tmr + 1'b1;
        end
      end
      ST_IDLE: begin
        if (q.init_cnt != '0) begin
          go         = 1'b1;
          d.init_cnt = q.init_cnt - 1'b1;
        end else if (q.ref_pend) begin
          go         = 1'b1;
          d.ref_pend = 1'b0;
        end else if (q.cmd_pend && q.init_done &&
                     !((q.cmd_req == CMD_RD_XFER ||
                        q.cmd_req == CMD_PSEUDO_WR) &&
                       (q.sst != SS_IDLE || q.s_left != '0))) begin
          // transfers wait for the serial side to be quiet
          go         = 1'b1;
          go_cmd     = q.cmd_req;
          d.cmd_pend = 1'b0;
        end
      end
      ST_SETUP: begin
        if (q.tmr == '0) begin
          d.st    = ST_ROW;
          d.tmr   = RCD_CYC - 1'b1;
          d.ras_n = 1'b0;
          if (!q.init_done) begin
            d.hlp_rfall = q.hlp_rfall + 1'b1;
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_ROW: begin
        if (q.tmr == '0) begin
          d.st     = ST_COL;
          d.tmr    = CAS_CYC - 1'b1;
          // early write: enable falls before the column strobe
          d.wmen_n = !wr;
          d.dq_oe  = wr;
          d.dq_o   = q.wdata;
          d.xfer_n = !(q.cmd == CMD_READ || q.cmd == CMD_RD_XFER);
          if (colc) begin
            d.addr_o = q.addr[COL_LSB +: ADR_W];
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_COL: begin
        if (colc) begin
          d.cas_n = 1'b0;
        end
        if (q.tmr == '0) begin
          d.st     = ST_PRE;
          d.tmr    = PRE_CYC - 1'b1;
          d.ras_n  = 1'b1;
          d.cas_n  = 1'b1;
          d.wmen_n = 1'b1;
          d.xfer_n = 1'b1;
          d.dq_oe  = 1'b0;
          if (q.cmd == CMD_READ) begin
            d.rdata = dq_if.safe;
          end
          // the serial pins follow the last transfer kind
          if (q.cmd == CMD_RD_XFER) begin
            d.ser_out = 1'b1;
          end else if (q.cmd == CMD_PSEUDO_WR) begin
            d.ser_out = 1'b0;
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_PRE: begin
        if (q.tmr == '0) begin
          d.st = ST_IDLE;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // pins for the row strobe fall are set one phase early
    if (go) begin
      d.st     = ST_SETUP;
      d.cmd    = go_cmd;
      d.tmr    = RCD_CYC - 1'b1;
      d.addr_o = q.addr[ROW_LSB +: ADR_W];
      d.cas_n  = !(go_cmd == CMD_COL_FIRST_REF);
      d.wmen_n = !(go_cmd == CMD_MASK_WR || go_cmd == CMD_PSEUDO_WR);
      d.xfer_n = !(go_cmd == CMD_RD_XFER || go_cmd == CMD_PSEUDO_WR);
      d.dq_oe  = (go_cmd == CMD_MASK_WR);
      d.dq_o   = q.mask;
    end

    // ****************************************
    // serial clock pulses
    // ****************************************
    case (q.sst)
      SS_IDLE: begin
        if (q.s_left != '0 && q.st != ST_SETUP && q.st != ST_ROW) begin
          d.sst    = SS_SET;
          d.s_left = q.s_left - 1'b1;
          // init pulses leave serial access disabled
          d.ser_en_n = !q.init_done;
          d.sdq_oe   = q.init_done && !q.ser_out;
          d.sdq_o    = q.sdata;
        end
      end
      SS_SET: begin
        d.sst       = SS_HI;
        d.stmr      = SH_CYC - 1'b1;
        d.shift_clk = 1'b1;
      end
      SS_HI: begin
        if (q.stmr == '0) begin
          d.sst       = SS_LO;
          d.stmr      = SH_CYC - 1'b1;
          d.shift_clk = 1'b0;
        end else begin
          d.stmr = q.stmr - 1'b1;
        end
      end
      SS_LO: begin
        if (q.stmr == '0) begin
          d.sst      = SS_IDLE;
          d.ser_en_n = 1'b1;
          d.sdq_oe   = 1'b0;
          if (q.init_done && q.ser_out) begin
            d.sdata = sdq_if.safe;
          end
        end else begin
          d.stmr = q.stmr - 1'b1;
        end
      end
      default: d.sst = SS_IDLE;
    endcase

    if (q.st == ST_IDLE && !q.init_done && q.init_cnt == '0 &&
        q.s_left == '0 && q.sst == SS_IDLE) begin
      d.init_done = 1'b1;
    end

    // refresh timer; a new request beats the clear above
    if (q.init_done && q.autoref) begin
      if (q.ref_tmr == '0) begin
        d.ref_tmr  = REF_CYC - 1'b1;
        d.ref_pend = 1'b1;
      end else begin
        d.ref_tmr = q.ref_tmr - 1'b1;
      end
    end
  end

  // the dram powers up with strobes high and the pins released
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      q          <= '0;
      q.ras_n    <= 1'b1;
      q.cas_n    <= 1'b1;
      q.wmen_n   <= 1'b1;
      q.xfer_n   <= 1'b1;
      q.ser_en_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign BUS_RDATA_O                = q.rd;
  assign ROW_STROBE_N_O             = q.ras_n;
  assign COL_STROBE_N_O             = q.cas_n;
  assign ADDR_O                     = q.addr_o;
  assign WRITE_MASK_ENABLE_N_O      = q.wmen_n;
  assign TRANSFER_OUTPUT_ENABLE_N_O = q.xfer_n;
  assign MASK_DATA_IO_O             = q.dq_o;
  assign MASK_DATA_IO_OE_O          = q.dq_oe;
  assign SERIAL_ENABLE_N_O          = q.ser_en_n;
  assign SERIAL_SHIFT_CLOCK_O       = q.shift_clk;
  assign SERIAL_DATA_IO_O           = q.sdq_o;
  assign SERIAL_DATA_IO_OE_O        = q.sdq_oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  ref_served_a: assert property (
    (q.init_done && q.autoref && q.ref_tmr == '0) |-> !q.ref_pend)
    else $error("refresh request not served within one interval");
  init_cycles_a: assert property (
    $rose(q.init_done) |-> q.hlp_rfall == INIT_CYCLES)
    else $error("wrong count of power-up refresh cycles");
  row_addr_a: assert property (
    ($fell(ROW_STROBE_N_O) && q.cmd != CMD_COL_FIRST_REF)
      |-> ADDR_O == q.addr[ROW_LSB +: ADR_W])
    else $error("row address wrong at row strobe fall");
  col_addr_a: assert property (
    $fell(COL_STROBE_N_O) && !ROW_STROBE_N_O
      |-> ADDR_O == q.addr[COL_LSB +: ADR_W])
    else $error("column address wrong at column strobe fall");
  mask_pins_a: assert property (
    ($fell(ROW_STROBE_N_O) && q.cmd == CMD_MASK_WR)
      |-> !WRITE_MASK_ENABLE_N_O && MASK_DATA_IO_OE_O &&
          MASK_DATA_IO_O == q.mask)
    else $error("mask not presented at row strobe fall");
  wdata_hold_a: assert property (
    ($fell(COL_STROBE_N_O) && (q.cmd == CMD_WRITE || q.cmd == CMD_MASK_WR))
      |-> (MASK_DATA_IO_OE_O && !WRITE_MASK_ENABLE_N_O &&
           MASK_DATA_IO_O == q.wdata) [*4])
    else $error("write data not held at column strobe fall");
  rd_xfer_a: assert property (
    ($fell(ROW_STROBE_N_O) && q.cmd == CMD_RD_XFER)
      |-> !TRANSFER_OUTPUT_ENABLE_N_O && WRITE_MASK_ENABLE_N_O
          ##[1:20] $fell(COL_STROBE_N_O))
    else $error("read transfer decode or tap strobe wrong");
  pseudo_wr_a: assert property (
    ($fell(ROW_STROBE_N_O) && q.cmd == CMD_PSEUDO_WR)
      |-> !TRANSFER_OUTPUT_ENABLE_N_O && !WRITE_MASK_ENABLE_N_O &&
          SERIAL_ENABLE_N_O)
    else $error("pseudo write transfer decode wrong");
  col_first_a: assert property (
    ($fell(ROW_STROBE_N_O) && !COL_STROBE_N_O)
      |-> q.cmd == CMD_COL_FIRST_REF)
    else $error("column strobe low at row fall outside refresh");
endmodule

`default_nettype wire

// >>> vdc_dram_model.sv
/*
  behavioural dual-port video dram seen from its pins.
  assumes the host drives strobes from a clock; no timing checks.
*/
`timescale 1ns/1ps
`default_nettype none

module vdc_dram_model (
  input  wire logic       ras_n_i,
  input  wire logic       cas_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       we_n_i,
  input  wire logic       xfer_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       dq_oe_i,
  input  wire logic       ser_en_n_i,
  input  wire logic       shift_clk_i,
  input  wire logic [7:0] sdq_i,
  input  wire logic       sdq_oe_i,
  output logic      [7:0] dq_o,
  output logic      [7:0] sdq_o
);
  // ****************************************
  // storage and cycle state
  // ****************************************
  logic [7:0] mem [65536]; // 256 rows of 2048 bits
  logic [7:0] ser [256];   // static, never refreshed
  logic [7:0] row, col, ptr, mask, dlast, slast;
  logic       xfer, to_ser, pw, mw, colf, seen, sout, rdo;
  int         col_first_cnt = 0;
  int         row_only_cnt = 0;
  int         shift_cnt = 0;

  initial begin
    sout = 1'b0;  // input mode, tap unknown
    ptr = 'x;
    dlast = 8'h00;
    slast = 8'h00;
  end

  // released pins show the inverse, not a stale copy
  assign rdo = !ras_n_i && !cas_n_i && seen && !xfer && !xfer_n_i &&
               we_n_i;
  assign dq_o = rdo ? mem[{row, col}] : ~dlast;
  assign sdq_o = (sout && !ser_en_n_i) ? slast : ~slast;
  always @(negedge rdo) dlast = mem[{row, col}];

  // ****************************************
  // random port
  // ****************************************
  // a set mask bit lets that bit be written
  task automatic wr_byte;
    mem[{row, col}] = (mem[{row, col}] & ~mask) | (dq_i & mask);
  endtask

  always @(negedge ras_n_i) begin
    row = addr_i;
    colf = !cas_n_i;
    xfer = !colf && !xfer_n_i;
    to_ser = we_n_i;
    pw = ser_en_n_i;
    mw = !colf && xfer_n_i && !we_n_i;
    mask = (mw && dq_oe_i) ? dq_i : 8'hff;
    seen = 1'b0;
    if (colf) col_first_cnt++;
  end

  always @(posedge ras_n_i) if (!colf && !seen) row_only_cnt++;

  always @(negedge cas_n_i) if (!ras_n_i) begin
    seen = 1'b1;
    col = addr_i;
    if (xfer) begin
      ptr = addr_i;
      sout = to_ser;
      for (int i = 0; i < 256; i++)
        if (to_ser) ser[i] = mem[{row, 8'(i)}];
        else if (!pw) mem[{row, 8'(i)}] = ser[i];
    end else if (!we_n_i) wr_byte(); // early write
  end

  // late write enable samples data at its own fall
  always @(negedge we_n_i)
    if (!ras_n_i && !cas_n_i && seen && !xfer) wr_byte();

  // ****************************************
  // serial port, free of the random port
  // ****************************************
  always @(posedge shift_clk_i) begin
    shift_cnt++;
    if (sout) slast = ser[ptr];
    else if (!ser_en_n_i && sdq_oe_i) ser[ptr] = sdq_i;
    ptr = ptr + 8'h01; // steps with enable high too, wraps
  end
endmodule

`default_nettype wire

// >>> tb.sv
/*
  self-checking bench of the video dram controller.
  assumes the dram model beside it and a short power-up wait.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import vdc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  a = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] q, rdat, adr [3];
  logic [7:0]  ad, dqo, dqd, sdo, sdd, ex;
  wire logic   ras, cas, we, xf, dqe, sen, sclk, sde;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          c0;

  always #2.5 clk = ~clk;

  vdc_ctrl #(.PWR_WAIT_CYC(20)) i_vdc_ctrl (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .BUS_ADDR_I(a), .BUS_WDATA_I(wd),
    .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdat),
    .ROW_STROBE_N_O(ras), .COL_STROBE_N_O(cas), .ADDR_O(ad),
    .WRITE_MASK_ENABLE_N_O(we), .TRANSFER_OUTPUT_ENABLE_N_O(xf),
    .MASK_DATA_IO_I(dqe ? dqo : dqd), .MASK_DATA_IO_O(dqo),
    .MASK_DATA_IO_OE_O(dqe), .SERIAL_ENABLE_N_O(sen),
    .SERIAL_SHIFT_CLOCK_O(sclk), .SERIAL_DATA_IO_I(sde ? sdo : sdd),
    .SERIAL_DATA_IO_O(sdo), .SERIAL_DATA_IO_OE_O(sde));

  vdc_dram_model i_vdc_dram_model (
    .ras_n_i(ras), .cas_n_i(cas), .addr_i(ad), .we_n_i(we), .xfer_n_i(xf),
    .dq_i(dqo), .dq_oe_i(dqe), .ser_en_n_i(sen), .shift_clk_i(sclk),
    .sdq_i(sdo), .sdq_oe_i(sde), .dq_o(dqd), .sdq_o(sdd));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic wrr(input logic [3:0] x, input logic [15:0] d);
    @(posedge clk);
    a <= x;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] x);
    @(posedge clk);
    a <= x;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdat;
  endtask

  // bounded poll of one status bit; running out counts as a mismatch
  task automatic wait_bit(input int b, input logic v);
    for (int n = 0; n < 600; n++) begin
      rdr(REG_STAT);
      if (q[b] === v) return;
    end
    chk(q, {16{v}});
  endtask

  task automatic cmd(input vdc_cmd_t c, input logic [15:0] x, d);
    wrr(REG_ADDR, x);
    wrr(REG_WDATA, d);
    wrr(REG_CTRL, 16'h0080 | 16'(c));
    wait_bit(STAT_BUSY, 1'b0);
  endtask

  task automatic sp(input logic [7:0] d);
    wrr(REG_SER, {8'h00, d});
    wait_bit(STAT_SBUSY, 1'b0);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hang cuts the run short well above the expected length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    adr = '{16'h0000, 16'hff01, 16'h12ff};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_bit(STAT_INIT, 1'b1);
    chk(16'(i_vdc_dram_model.col_first_cnt), 16'h0008);
    chk(16'(i_vdc_dram_model.shift_cnt), 16'h0008);
    $display("test init done");
    for (int i = 0; i < 3; i++)
      cmd(CMD_WRITE, adr[i], {8'h00, 8'h5a ^ adr[i][7:0]});
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_READ, adr[i], 16'h0000);
      rdr(REG_RDATA);
      ex = 8'h5a ^ adr[i][7:0];
      chk(q, {8'h00, ex});
      chk({8'h00, i_vdc_dram_model.mem[adr[i]]}, {8'h00, ex});
    end
    $display("test write read done");
    cmd(CMD_WRITE, 16'h4242, 16'h00a5);
    wrr(REG_MASK, 16'h000f);
    cmd(CMD_MASK_WR, 16'h4242, 16'h005a);
    cmd(CMD_READ, 16'h4242, 16'h0000);
    rdr(REG_RDATA);
    chk(q, 16'h00aa);
    $display("test masked write done");
    cmd(CMD_WRITE, 16'h30fe, 16'h0011);
    cmd(CMD_WRITE, 16'h30ff, 16'h0022);
    cmd(CMD_WRITE, 16'h3000, 16'h0033);
    cmd(CMD_RD_XFER, 16'h30fe, 16'h0000);
    rdr(REG_STAT);
    chk(16'(q[STAT_SOUT]), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      sp(8'h00);
      rdr(REG_SER);
      chk(q, 16'h0011 * 16'(i + 1));
    end
    $display("test read transfer done");
    cmd(CMD_PSEUDO_WR, 16'h0005, 16'h0000);
    rdr(REG_STAT);
    chk(16'(q[STAT_SOUT]), 16'h0000);
    sp(8'h3c);
    sp(8'hc3);
    chk({8'h00, i_vdc_dram_model.ser[5]}, 16'h003c);
    chk({8'h00, i_vdc_dram_model.ser[6]}, 16'h00c3);
    $display("test serial write done");
    c0 = i_vdc_dram_model.row_only_cnt;
    cmd(CMD_ROW_ONLY_REF, 16'h0700, 16'h0000);
    chk(16'(i_vdc_dram_model.row_only_cnt - c0), 16'h0001);
    c0 = i_vdc_dram_model.col_first_cnt;
    cmd(CMD_COL_FIRST_REF, 16'h0000, 16'h0000);
    chk(16'(i_vdc_dram_model.col_first_cnt - c0), 16'h0001);
    rdr(4'h7);
    chk(q, 16'h0000);
    $display("test refresh and unmapped done");
    c0 = i_vdc_dram_model.col_first_cnt;
    wrr(REG_CTRL, 16'h0010);
    // one refresh at once, the next one interval of 3125 cycles later
    repeat (3200) @(posedge clk);
    chk(16'(i_vdc_dram_model.col_first_cnt - c0), 16'h0002);
    $display("test auto refresh done");
    finish_test();
  end
endmodule

`default_nettype wire
